// ---- rtl/msl_defines.svh ----
// Constants of the multiply-accumulate slice: offsets, field positions, resets, widths
// Behaviour
// RL1: Normal mode multiplies signed 18-bit A and B into a 36-bit product.
// RL2: Unsigned products of operands up to 17 bits are supported as well.
// RL3: Dot mode uses two 9x9 multipliers: A low by B high plus A high by B low.
// RL4: The dot-mode sum sits in the upper 35 of 44 bits, scaled by 512.
// RL5: Add result equals product plus C plus D plus carry-in.
// RL6: The adder may take product plus C, product plus D, or all three.
// RL7: Subtract result equals C plus D plus carry-in minus the product.
// RL8: A, B, C, P and control registers exist and each can be bypassed.
// RL9: Operand C is a registered 44-bit input apart from the multiplier inputs.
// RL10: Every register holds its value while its enable is low.
// RL11: Chain input reaches the D path with no register in the slice.
// RL12: Chain output carries the result; slices chain output to next input.
// RL13: Chain select high picks the chain input for D, shifted when asked.
// RL14: Loopback select picks the own result for D; both selects low give zero.
// RL15: With shift asserted the chosen D source is shifted right arithmetically.
// RL16: An overflow flag marks adder overflow for width extension outside.
// RL17: Outside logic saturates using the overflow flag and result sign bit.
// RL18: Upper tick drives upper halves, upper result and control; lower tick the rest. The code clocks C on the upper tick as well.
// RL19: In normal mode outside logic drives both halves of each pair alike.
// RL20: Operand halves each have async and sync active-low clears of their own.
// RL21: Dot mode is chosen by a static configuration bit; otherwise normal mode.
// RL22: The 44-bit result wraps in two's complement, never saturates internally.
// RL23: Each enabled register stage adds exactly one cycle on its tick.
`ifndef MSL_DEFINES_SVH
`define MSL_DEFINES_SVH
`define MSL_CFG_OFFSET    12'h000
`define MSL_STAT_OFFSET   12'h004
`define MSL_RESLO_OFFSET  12'h008
`define MSL_RESHI_OFFSET  12'h00C
`define MSL_CFG_RESET     11'h600
`define MSL_CFG_DUAL      0
`define MSL_CFG_UNSIGNED  1
`define MSL_CFG_A_BYP_LO  2
`define MSL_CFG_A_BYP_HI  3
`define MSL_CFG_B_BYP_LO  4
`define MSL_CFG_B_BYP_HI  5
`define MSL_CFG_C_BYP     6
`define MSL_CFG_P_BYP     7
`define MSL_CFG_CTRL_BYP  8
`define MSL_CFG_ADD_C     9
`define MSL_CFG_ADD_D     10
`define MSL_CFG_WIDTH     11
`define MSL_SHIFT         17
`define MSL_DOT_SCALE     9
`endif

// ---- rtl/msl_pkg.sv ----
// Types shared by the multiply-accumulate slice
package msl_pkg;
   typedef struct packed {
      logic chain_select;
      logic loopback_select;
      logic shift_right_seventeen;
      logic subtract_select;
      logic adder_carry_input;
   } msl_ctrl_t;
endpackage : msl_pkg

// ---- rtl/msl_slice.sv ----
// Multiply-accumulate slice with register stages and APB configuration port
`timescale 1ns/1ps
`default_nettype none
`include "msl_defines.svh"

// ==========================================================================
// Register stage: tick-gated, enable, sync clear, async clear, bypass
// ==========================================================================
module msl_stage #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         tick,
   input  wire logic         en,
   input  wire logic         sclr_n,
   input  wire logic         bypass,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q,
   output logic      [W-1:0] qr
);
   logic [W-1:0] q_reg;
   logic [W-1:0] q_next;

   always_comb begin
      q_next = q_reg;
      if (tick) begin
         if (!sclr_n) begin
            q_next = '0;
         end else if (en) begin // RL10 RL23
            q_next = d;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q_reg <= '0;
      end else begin
         q_reg <= q_next;
      end
   end

   assign q  = bypass ? d : q_reg; // RL8
   assign qr = q_reg;
endmodule : msl_stage

// ==========================================================================
// Slice top
// ==========================================================================
module msl_slice
   import msl_pkg::*;
(
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [11:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  wire logic [1:0]       clock_tick,
   input  wire logic [17:0]      operand_a,
   input  wire logic [1:0]       operand_a_enable,
   input  wire logic [1:0]       operand_a_async_clear_n,
   input  wire logic [1:0]       operand_a_sync_clear_n,
   input  wire logic [17:0]      operand_b,
   input  wire logic [1:0]       operand_b_enable,
   input  wire logic [1:0]       operand_b_async_clear_n,
   input  wire logic [1:0]       operand_b_sync_clear_n,
   input  wire logic [43:0]      operand_c,
   input  wire logic             operand_c_enable,
   input  wire logic             operand_c_async_clear_n,
   input  wire logic             operand_c_sync_clear_n,
   input  wire msl_ctrl_t        ctrl_in,
   input  wire logic             ctrl_enable,
   input  wire logic [43:0]      chain_in,
   input  wire logic [1:0]       result_enable,
   input  wire logic [1:0]       result_async_clear_n,
   input  wire logic [1:0]       result_sync_clear_n,
   output logic      [43:0]      result,
   output logic      [43:0]      chain_out,
   output logic                  overflow_flag
);
   // =======================================================================
   // Configuration and APB slave
   // =======================================================================
   logic [`MSL_CFG_WIDTH-1:0] cfg_reg;
   logic [`MSL_CFG_WIDTH-1:0] cfg_next;
   logic                      pready_reg;
   logic                      pready_next;
   logic [31:0]               prdata_reg;
   logic [31:0]               prdata_next;
   logic                      pslverr_reg;
   logic                      pslverr_next;
   logic [43:0]               p_full_r;
   logic                      ovfl_r;
   logic                      known;

   // One wait state: data and ready are registered in the first access cycle
   always_comb begin
      cfg_next     = cfg_reg;
      pready_next  = 1'b0;
      prdata_next  = prdata_reg;
      pslverr_next = 1'b0;
      known        = (paddr == `MSL_CFG_OFFSET) || (paddr == `MSL_STAT_OFFSET) ||
                     (paddr == `MSL_RESLO_OFFSET) || (paddr == `MSL_RESHI_OFFSET);
      if (psel && penable && !pready_reg) begin
         pready_next  = 1'b1;
         pslverr_next = !known;
         prdata_next  = 32'h0000_0000;
         if (!pwrite) begin
            unique case (paddr)
               `MSL_CFG_OFFSET:   prdata_next = {21'h00_0000, cfg_reg};
               `MSL_STAT_OFFSET:  prdata_next = {30'h0000_0000, cfg_reg[`MSL_CFG_DUAL], ovfl_r};
               `MSL_RESLO_OFFSET: prdata_next = p_full_r[31:0];
               `MSL_RESHI_OFFSET: prdata_next = {20'h0_0000, p_full_r[43:32]};
               default:           prdata_next = 32'h0000_0000;
            endcase
         end
      end
      if (psel && penable && pready_reg && pwrite && (paddr == `MSL_CFG_OFFSET)) begin
         cfg_next = pwdata[`MSL_CFG_WIDTH-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg     <= `MSL_CFG_RESET;
         pready_reg  <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else begin
         cfg_reg     <= cfg_next;
         pready_reg  <= pready_next;
         prdata_reg  <= prdata_next;
         pslverr_reg <= pslverr_next;
      end
   end

   assign pready  = pready_reg;
   assign prdata  = prdata_reg;
   assign pslverr = pslverr_reg;

   // =======================================================================
   // Input and control stages
   // =======================================================================
   logic [8:0]  a_hi_q, a_lo_q, b_hi_q, b_lo_q;
   logic [43:0] c_q;
   msl_ctrl_t   ctrl_q;

   // Async clears are merged with the bus reset; a pin clear acts at once
   msl_stage #(.W(9)) u_a_hi (.clk(pclk), .rst_n(presetn & operand_a_async_clear_n[1]),
      .tick(clock_tick[1]), .en(operand_a_enable[1]), .sclr_n(operand_a_sync_clear_n[1]),
      .bypass(cfg_reg[`MSL_CFG_A_BYP_HI]), .d(operand_a[17:9]), .q(a_hi_q), .qr()); // RL18 RL20
   msl_stage #(.W(9)) u_a_lo (.clk(pclk), .rst_n(presetn & operand_a_async_clear_n[0]),
      .tick(clock_tick[0]), .en(operand_a_enable[0]), .sclr_n(operand_a_sync_clear_n[0]),
      .bypass(cfg_reg[`MSL_CFG_A_BYP_LO]), .d(operand_a[8:0]), .q(a_lo_q), .qr()); // RL18 RL20
   msl_stage #(.W(9)) u_b_hi (.clk(pclk), .rst_n(presetn & operand_b_async_clear_n[1]),
      .tick(clock_tick[1]), .en(operand_b_enable[1]), .sclr_n(operand_b_sync_clear_n[1]),
      .bypass(cfg_reg[`MSL_CFG_B_BYP_HI]), .d(operand_b[17:9]), .q(b_hi_q), .qr()); // RL18 RL20
   msl_stage #(.W(9)) u_b_lo (.clk(pclk), .rst_n(presetn & operand_b_async_clear_n[0]),
      .tick(clock_tick[0]), .en(operand_b_enable[0]), .sclr_n(operand_b_sync_clear_n[0]),
      .bypass(cfg_reg[`MSL_CFG_B_BYP_LO]), .d(operand_b[8:0]), .q(b_lo_q), .qr()); // RL18 RL20
   msl_stage #(.W(44)) u_c (.clk(pclk), .rst_n(presetn & operand_c_async_clear_n),
      .tick(clock_tick[1]), .en(operand_c_enable), .sclr_n(operand_c_sync_clear_n),
      .bypass(cfg_reg[`MSL_CFG_C_BYP]), .d(operand_c), .q(c_q), .qr()); // RL9
   msl_stage #(.W($bits(msl_ctrl_t))) u_ctrl (.clk(pclk), .rst_n(presetn),
      .tick(clock_tick[1]), .en(ctrl_enable), .sclr_n(1'b1),
      .bypass(cfg_reg[`MSL_CFG_CTRL_BYP]), .d(ctrl_in), .q(ctrl_q), .qr()); // RL18

   // =======================================================================
   // Multiplier
   // =======================================================================
   logic [17:0]        a_q, b_q, a_ext, b_ext;
   logic signed [35:0] prod_n;
   logic signed [17:0] pp_lh, pp_hl;
   logic signed [18:0] dot_sum;
   logic [43:0]        prod44;

   assign a_q = {a_hi_q, a_lo_q};
   assign b_q = {b_hi_q, b_lo_q};
   // Unsigned mode: bit 17 forced low so the signed array yields 17x17 unsigned
   assign a_ext = cfg_reg[`MSL_CFG_UNSIGNED] ? {1'b0, a_q[16:0]} : a_q; // RL2
   assign b_ext = cfg_reg[`MSL_CFG_UNSIGNED] ? {1'b0, b_q[16:0]} : b_q; // RL2
   assign prod_n  = $signed(a_ext) * $signed(b_ext); // RL1
   assign pp_lh   = $signed(a_lo_q) * $signed(b_hi_q); // RL3
   assign pp_hl   = $signed(a_hi_q) * $signed(b_lo_q); // RL3
   assign dot_sum = {pp_lh[17], pp_lh} + {pp_hl[17], pp_hl}; // RL3
   assign prod44  = cfg_reg[`MSL_CFG_DUAL] ?
                    {{16{dot_sum[18]}}, dot_sum, 9'h000} : // RL4 RL21
                    {{8{prod_n[35]}}, prod_n};

   // =======================================================================
   // D selection and adder
   // =======================================================================
   logic [43:0]        d_src, d_val, c_term, d_term;
   logic signed [45:0] pw, cw, dw, cinw, wide;

   always_comb begin
      if (ctrl_q.chain_select) begin
         d_src = chain_in; // RL11 RL13
      end else if (ctrl_q.loopback_select) begin
         d_src = p_full_r; // RL14
      end else begin
         d_src = 44'h000_0000_0000; // RL14
      end
   end

   assign d_val  = ctrl_q.shift_right_seventeen ?
                   44'($signed(d_src) >>> `MSL_SHIFT) : d_src; // RL15
   assign c_term = cfg_reg[`MSL_CFG_ADD_C] ? c_q : 44'h000_0000_0000; // RL6
   assign d_term = cfg_reg[`MSL_CFG_ADD_D] ? d_val : 44'h000_0000_0000; // RL6
   assign pw     = {{2{prod44[43]}}, prod44};
   assign cw     = {{2{c_term[43]}}, c_term};
   assign dw     = {{2{d_term[43]}}, d_term};
   assign cinw   = {45'h0000_0000_0000, ctrl_q.adder_carry_input};
   assign wide   = ctrl_q.subtract_select ? (cw + dw + cinw - pw) : // RL7
                                            (pw + cw + dw + cinw); // RL5

   // =======================================================================
   // Result stages; overflow is any 46-bit sum not fitting 44 signed bits
   // =======================================================================
   logic [25:0] p_hi_q, p_hi_r;
   logic [17:0] p_lo_q, p_lo_r;
   logic        ovfl_d, ovfl_q;

   assign ovfl_d = !((wide[45:43] == 3'h0) || (wide[45:43] == 3'h7)); // RL16

   msl_stage #(.W(26)) u_p_hi (.clk(pclk), .rst_n(presetn & result_async_clear_n[1]),
      .tick(clock_tick[1]), .en(result_enable[1]), .sclr_n(result_sync_clear_n[1]),
      .bypass(cfg_reg[`MSL_CFG_P_BYP]), .d(wide[43:18]), .q(p_hi_q), .qr(p_hi_r)); // RL18 RL22
   msl_stage #(.W(18)) u_p_lo (.clk(pclk), .rst_n(presetn & result_async_clear_n[0]),
      .tick(clock_tick[0]), .en(result_enable[0]), .sclr_n(result_sync_clear_n[0]),
      .bypass(cfg_reg[`MSL_CFG_P_BYP]), .d(wide[17:0]), .q(p_lo_q), .qr(p_lo_r)); // RL18 RL22
   msl_stage #(.W(1)) u_ovfl (.clk(pclk), .rst_n(presetn & result_async_clear_n[1]),
      .tick(clock_tick[1]), .en(result_enable[1]), .sclr_n(result_sync_clear_n[1]),
      .bypass(cfg_reg[`MSL_CFG_P_BYP]), .d(ovfl_d), .q(ovfl_q), .qr(ovfl_r)); // RL16

   // Loopback always reads the register, so a bypassed result makes no loop
   assign p_full_r      = {p_hi_r, p_lo_r};
   assign result        = {p_hi_q, p_lo_q};
   assign chain_out     = {p_hi_q, p_lo_q}; // RL12
   assign overflow_flag = ovfl_q; // RL16 RL17

   // =======================================================================
   // Assertions
   // =======================================================================
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence upper_load_s;
      clock_tick[1] && result_enable[1] && result_sync_clear_n[1] &&
      result_async_clear_n[1];
   endsequence
   sequence upper_idle_s;
      !clock_tick[1] && result_async_clear_n[1];
   endsequence
   sequence lower_load_s;
      clock_tick[0] && result_enable[0] && result_sync_clear_n[0] &&
      result_async_clear_n[0];
   endsequence

   normal_product_a: assert property (!cfg_reg[`MSL_CFG_DUAL] && !cfg_reg[`MSL_CFG_UNSIGNED]
      |-> 44'(prod44) == 44'($signed(a_q) * $signed(b_q))) // RL1
      else $error("normal product wrong");
   unsigned_product_a: assert property (cfg_reg[`MSL_CFG_UNSIGNED] && !cfg_reg[`MSL_CFG_DUAL]
      |-> prod44 == 44'({27'h0, a_q[16:0]} * {27'h0, b_q[16:0]})) // RL2
      else $error("unsigned product wrong");
   dot_product_a: assert property (cfg_reg[`MSL_CFG_DUAL]
      |-> prod44 == 44'((44'($signed(a_lo_q) * $signed(b_hi_q))
          + 44'($signed(a_hi_q) * $signed(b_lo_q))) << `MSL_DOT_SCALE)) // RL3 RL4
      else $error("dot product wrong");
   add_result_a: assert property (!ctrl_q.subtract_select
      |-> wide[43:0] == 44'(prod44 + c_term + d_term + 44'(ctrl_q.adder_carry_input))) // RL5
      else $error("add result wrong");
   sub_result_a: assert property (ctrl_q.subtract_select
      |-> wide[43:0] == 44'(c_term + d_term + 44'(ctrl_q.adder_carry_input) - prod44)) // RL7
      else $error("subtract result wrong");
   chain_pick_a: assert property (ctrl_q.chain_select && !ctrl_q.shift_right_seventeen
      && cfg_reg[`MSL_CFG_ADD_D] |-> d_term == chain_in) // RL13
      else $error("chain operand wrong");
   loop_pick_a: assert property (!ctrl_q.chain_select && !ctrl_q.shift_right_seventeen
      |-> d_val == (ctrl_q.loopback_select ? p_full_r : 44'h000_0000_0000)) // RL14
      else $error("loopback operand wrong");
   shift_fill_a: assert property (ctrl_q.shift_right_seventeen
      |-> d_val[43:27] == {17{d_src[43]}} && d_val[26:0] == d_src[43:17]) // RL15
      else $error("shift fill wrong");
   upper_latency_a: assert property (upper_load_s ##1 result_async_clear_n[1]
      |-> p_hi_r == $past(wide[43:18]) && ovfl_r == $past(ovfl_d)) // RL23
      else $error("result stage latency wrong");
   upper_hold_a: assert property (upper_idle_s ##1 result_async_clear_n[1]
      |-> $stable(p_hi_r) && $stable(ovfl_r)) // RL10
      else $error("result stage did not hold");
   lower_latency_a: assert property (lower_load_s ##1 result_async_clear_n[0] // RL18
      |-> p_lo_r == $past(wide[17:0]))
      else $error("lower result stage latency wrong");
   upper_clear_a: assert property (clock_tick[1] && !result_sync_clear_n[1] // RL20
      ##1 result_async_clear_n[1] |-> p_hi_r == 26'h0)
      else $error("result stage sync clear failed");
   // Ties the chain port to the stage it must come from, not to the result port
   chain_copy_a: assert property (chain_out == // RL12
      (cfg_reg[`MSL_CFG_P_BYP] ? wide[43:0] : p_full_r))
      else $error("chain output differs from result");
endmodule : msl_slice
`default_nettype wire

// ---- sim/msl_fabric_model.sv ----
// Fabric model: neighbour slice chain register and outside saturation logic
`timescale 1ns/1ps
`default_nettype none
module msl_fabric_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [43:0] nbr_value,
   input  wire logic [43:0] result,
   input  wire logic        overflow_flag,
   output logic      [43:0] chain_feed,
   output logic      [43:0] saturated
);
   // ===========================================================
   // Neighbour chain output, pipelined in fabric
   // ===========================================================
   // The slice has no chain input register, so the neighbour supplies one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) chain_feed <= '0;
      else chain_feed <= nbr_value;
   end
   // ===========================================================
   // Saturation from overflow and result sign
   // ===========================================================
   always_comb begin
      saturated = result;
      if (overflow_flag) saturated = result[43] ? 44'h7FFFFFFFFFF : 44'h80000000000;
   end
endmodule : msl_fabric_model
`default_nettype wire

// ---- sim/tb_msl_slice.sv ----
// Self-checking testbench of the multiply-accumulate slice
`timescale 1ns/1ps
`default_nettype none
`include "msl_defines.svh"
module tb_msl_slice;
   import msl_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0]  clock_tick, a_en, a_ac, a_sc, b_en, b_ac, b_sc, r_en, r_ac, r_sc;
   logic [17:0] op_a, op_b;
   logic [43:0] op_c, chain_in, result, chain_out, nbr_value, saturated;
   logic        c_en, c_ac, c_sc, ctrl_en, overflow_flag;
   msl_ctrl_t   ctrl;
   int          n_mismatch, comparisons;

   msl_slice dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .clock_tick(clock_tick), .operand_a(op_a), .operand_a_enable(a_en),
      .operand_a_async_clear_n(a_ac), .operand_a_sync_clear_n(a_sc), .operand_b(op_b),
      .operand_b_enable(b_en), .operand_b_async_clear_n(b_ac), .operand_b_sync_clear_n(b_sc),
      .operand_c(op_c), .operand_c_enable(c_en), .operand_c_async_clear_n(c_ac),
      .operand_c_sync_clear_n(c_sc), .ctrl_in(ctrl), .ctrl_enable(ctrl_en),
      .chain_in(chain_in), .result_enable(r_en), .result_async_clear_n(r_ac),
      .result_sync_clear_n(r_sc), .result(result), .chain_out(chain_out),
      .overflow_flag(overflow_flag));
   msl_fabric_model fab_u (.pclk(pclk), .presetn(presetn), .nbr_value(nbr_value),
      .result(chain_out), .overflow_flag(overflow_flag), .chain_feed(chain_in),
      .saturated(saturated));

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // ===========================================================
   // Tasks
   // ===========================================================
   task chk(input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Waits as long as the slave needs; only the watchdog ends a hung transfer
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   // All stages bypassed: result follows operands in the same cycle
   task run(input logic [31:0] cfg, input logic [4:0] c5, input logic [17:0] a, b,
            input logic [43:0] c, ch, exp, input logic ovf);
      apb(1'b1, `MSL_CFG_OFFSET, cfg);
      @(posedge pclk);
      ctrl <= msl_ctrl_t'(c5); op_a <= a; op_b <= b; op_c <= c; nbr_value <= ch;
      repeat (2) @(posedge pclk);
      #1;
      chk(result, exp);
      chk(chain_out, exp);
      chk(overflow_flag, ovf);
   endtask : run
   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : tally_and_finish
   // ===========================================================
   // Tests
   // ===========================================================
   initial begin
      #200000;
      n_mismatch++;
      tally_and_finish;
   end
   initial begin
      n_mismatch = 0; comparisons = 0; presetn = 1'b0;
      psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
      clock_tick = 2'b11; a_en = 2'b11; b_en = 2'b11; r_en = 2'b11;
      a_ac = 2'b11; a_sc = 2'b11; b_ac = 2'b11; b_sc = 2'b11; r_ac = 2'b11; r_sc = 2'b11;
      c_en = 1'b1; c_ac = 1'b1; c_sc = 1'b1; ctrl_en = 1'b1; ctrl = '0;
      op_a = '0; op_b = '0; op_c = '0; nbr_value = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `MSL_CFG_OFFSET, 32'h0);
      chk(rd, 32'h600);
      apb(1'b0, 12'h010, 32'h0);
      chk({err, rd}, {1'b1, 32'h0});
      // Registered accumulate: operands then result, one tick each
      @(posedge pclk);
      op_a <= 18'h3; op_b <= 18'h5; ctrl <= msl_ctrl_t'(5'b01000);
      repeat (2) @(posedge pclk);
      #1 chk(result, 44'hF);
      repeat (2) @(posedge pclk);
      #1 chk(result, 44'h2D);
      @(posedge pclk);
      r_en <= 2'b00;
      repeat (3) @(posedge pclk);
      #1 chk(result, 44'h3C);
      apb(1'b0, `MSL_RESLO_OFFSET, 32'h0);
      chk(rd, 32'h3C);
      @(posedge pclk);
      r_sc <= 2'b00;
      @(posedge pclk);
      r_sc <= 2'b11;
      r_en <= 2'b11;
      #1 chk(result, 44'h0);
      repeat (2) @(posedge pclk);
      r_ac <= 2'b00;
      #1 chk(result, 44'h0);
      @(posedge pclk);
      r_ac <= 2'b11;
      // Ticks off: the result must not accumulate even with enables high
      clock_tick <= 2'b00;
      repeat (3) @(posedge pclk);
      clock_tick <= 2'b11;
      #1 chk(result, 44'h0);
      $display("registered tests done");
      run(32'h7FC, 5'b00000, 18'h3FFFD, 18'h5, 44'd100, 44'h0, 44'h55, 1'b0);
      run(32'h7FC, 5'b00011, 18'h3FFFD, 18'h5, 44'd100, 44'h0, 44'h74, 1'b0);
      run(32'h7FE, 5'b00000, 18'h3FFFF, 18'h3FFFF, 44'h0, 44'h0, 44'h3FFFC0001, 1'b0);
      run(32'h7FD, 5'b00000, 18'h005FF, 18'h00805, 44'h0, 44'h0, 44'hC00, 1'b0);
      run(32'h7FC, 5'b10000, 18'h2, 18'h3, 44'd10, 44'd7, 44'h17, 1'b0);
      run(32'h3FC, 5'b10000, 18'h2, 18'h3, 44'd10, 44'd7, 44'h10, 1'b0);
      run(32'h5FC, 5'b11000, 18'h2, 18'h3, 44'd10, 44'd7, 44'hD, 1'b0);
      run(32'h7FC, 5'b10100, 18'h0, 18'h0, 44'h0, 44'h80000060000, 44'hFFFFC000003,
          1'b0);
      run(32'h7FC, 5'b00000, 18'h1, 18'h1, 44'h7FFFFFFFFFF, 44'h0, 44'h80000000000,
          1'b1);
      chk(saturated, 44'h7FFFFFFFFFF);
      apb(1'b0, `MSL_STAT_OFFSET, 32'h0);
      chk(rd, 32'h1);
      apb(1'b0, `MSL_RESHI_OFFSET, 32'h0);
      chk(rd, 32'h800);
      $display("bypass tests done");
      tally_and_finish;
   end
endmodule : tb_msl_slice
`default_nettype wire
